// file: design/sst_slave_tx.sv
`timescale 1ns/1ps

module sst_slave_tx (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port.
    input wire sst_pkg::sst_sfr_req_t sfrReq,
    output logic [7:0] sfrRdData,
    // Bit rate sources, one-cycle overflow pulses.
    input wire logic [3:0] timerOvf,
    // Crossbar pins, open drain; oeN low while pulling the pin low.
    input wire sst_pkg::sst_pin_in_t pinIn,
    output logic pinLowOut,
    output logic pinLowOeN,
    output logic pinHighOut,
    output logic pinHighOeN,
    // Bus bytes seen on the wire.
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] rxData,
    // Event flag level.
    output logic eventFlag
);

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_SWACK, S_ACK, S_TXWAIT, S_TX, S_TXACK, S_SKIP
    } sst_state_t;

    // ----------------------------------------
    // Helpers.
    // ----------------------------------------

    // Own address compared only where the mask holds a one, plus general call.
    function automatic logic addrMatch(input logic [7:0] rx, input logic [7:0] own,
                                       input logic [7:0] msk);
        logic hit;
        hit = ((rx[7:1] & msk[7:1]) == (own[7:1] & msk[7:1]));
        if (own[sst_pkg::OWN_GC] && rx[7:1] == sst_pkg::GENERAL_CALL[7:1]) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : addrMatch

    function automatic logic [3:0] startWindow(input logic [1:0] code);
        logic [3:0] w;
        case (code)
            2'b00: w = sst_pkg::SDD_WIN0;
            2'b01: w = sst_pkg::SDD_WIN1;
            2'b10: w = sst_pkg::SDD_WIN2;
            default: w = sst_pkg::SDD_WIN3;
        endcase
        return w;
    endfunction : startWindow

    // ----------------------------------------
    // Registers.
    // ----------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] config_ff;
    logic [7:0] timing_ff;
    logic [7:0] own_ff;
    logic [7:0] mask_ff;
    logic [7:0] shift_ff;
    sst_state_t state_ff;
    logic [7:0] nxt_rdData;
    logic [7:0] rdData_ff;
    logic wrCtrl;
    logic wrData;
    logic enabled;
    logic hwAck;

    assign wrCtrl = sfrReq.wr && sfrReq.addr == sst_pkg::ADDR_CTRL;
    assign wrData = sfrReq.wr && sfrReq.addr == sst_pkg::ADDR_DATA;
    assign enabled = config_ff[sst_pkg::CFG_ENABLE];
    assign hwAck = mask_ff[sst_pkg::MASK_HWACK];

    // ----------------------------------------
    // Pin sampling and swap.
    // ----------------------------------------
    logic [1:0] pinMeta_ff;
    logic [1:0] pinSync_ff;
    logic sdaPrev_ff;
    logic sclPrev_ff;
    logic sda;
    logic scl;
    logic sclRise;
    logic sclFall;
    logic sdaFall;
    logic sdaRise;
    logic holdScl;
    logic pullSda;

    // Two stages before anything looks at the pins.
    always_ff @(posedge clk) begin
        if (reset) begin
            pinMeta_ff <= 2'b11;
            pinSync_ff <= 2'b11;
            sdaPrev_ff <= 1'b1;
            sclPrev_ff <= 1'b1;
        end else begin
            pinMeta_ff <= {pinIn.highIn, pinIn.lowIn};
            pinSync_ff <= pinMeta_ff;
            sdaPrev_ff <= sda;
            sclPrev_ff <= scl;
        end
    end

    assign sda = timing_ff[sst_pkg::TC_SWAP] ? pinSync_ff[1] : pinSync_ff[0];
    assign scl = timing_ff[sst_pkg::TC_SWAP] ? pinSync_ff[0] : pinSync_ff[1];
    assign sclRise = scl && !sclPrev_ff;
    assign sclFall = !scl && sclPrev_ff;
    assign sdaFall = !sda && sdaPrev_ff;
    assign sdaRise = sda && !sdaPrev_ff;

    // Open drain: only ever drive low, and only while enabled.
    always_comb begin
        pinLowOut = 1'b0;
        pinHighOut = 1'b0;
        pinLowOeN = !(enabled && (timing_ff[sst_pkg::TC_SWAP] ? holdScl : pullSda));
        pinHighOeN = !(enabled && (timing_ff[sst_pkg::TC_SWAP] ? pullSda : holdScl));
    end

    // ----------------------------------------
    // Start and stop detection.
    // ----------------------------------------
    logic [3:0] winCnt_ff;
    logic armed_ff;
    logic startDet;
    logic stopDet;

    // A start only counts if clock stays high for the whole window after data falls.
    assign startDet = armed_ff && winCnt_ff == 4'h0 && scl && !sda;
    assign stopDet = sdaRise && scl;
    always_ff @(posedge clk) begin
        if (reset) begin
            armed_ff <= 1'b0;
            winCnt_ff <= 4'h0;
        end else if (sdaFall && scl) begin
            armed_ff <= 1'b1;
            winCnt_ff <= startWindow(timing_ff[1:0]);
        end else if (armed_ff) begin
            if (!scl || sda || winCnt_ff == 4'h0) begin
                armed_ff <= 1'b0;
            end else begin
                winCnt_ff <= winCnt_ff - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Bit rate tick and master start.
    // ----------------------------------------
    logic rateTick;
    logic [1:0] mPhase_ff;
    logic arbLoss;

    assign rateTick = timerOvf[config_ff[1:0]];
    // Another master pulling the clock while ours is pending means we lost.
    assign arbLoss = mPhase_ff == 2'd1 && !scl;

    always_ff @(posedge clk) begin
        if (reset || !enabled) begin
            mPhase_ff <= 2'd0;
        end else if (arbLoss) begin
            mPhase_ff <= 2'd0;
        end else if (rateTick) begin
            case (mPhase_ff)
                2'd0: if (ctrl_ff[sst_pkg::CTRL_STA] && state_ff == S_IDLE && sda && scl) begin
                    mPhase_ff <= 2'd1;
                end
                2'd1: mPhase_ff <= 2'd2;
                2'd2: if (ctrl_ff[sst_pkg::CTRL_STO]) begin
                    mPhase_ff <= 2'd3;
                end
                default: mPhase_ff <= 2'd0;
            endcase
        end
    end

    // ----------------------------------------
    // Slave sequencer.
    // ----------------------------------------
    logic txBit_ff;
    logic [3:0] bitCnt_ff;
    logic ignore_ff;
    logic dataWritten_ff;
    logic pendPush_ff;
    logic bufReady;
    logic byteEnd;
    logic setSi;

    assign byteEnd = sclFall && bitCnt_ff == sst_pkg::BITS_PER_BYTE;
    assign pullSda = state_ff == S_ACK || (state_ff == S_TX && !txBit_ff)
        || mPhase_ff != 2'd0;
    // Clock is stretched while software owes an answer or the buffer is full.
    assign holdScl = ((state_ff == S_SWACK || state_ff == S_TXWAIT) && ctrl_ff[sst_pkg::CTRL_SI])
        || pendPush_ff || mPhase_ff == 2'd2;

    always_ff @(posedge clk) begin
        if (reset || !enabled) begin
            state_ff <= S_IDLE;
            bitCnt_ff <= 4'h0;
            ignore_ff <= 1'b0;
        end else if (startDet || arbLoss) begin
            state_ff <= S_ADDR;
            bitCnt_ff <= 4'h0;
            ignore_ff <= 1'b0;
        end else if (stopDet) begin
            state_ff <= S_IDLE;
        end else begin
            if (sclRise && state_ff inside {S_ADDR, S_TX}) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
            end
            case (state_ff)
                S_ADDR: if (byteEnd) begin
                    bitCnt_ff <= 4'h0;
                    if (config_ff[sst_pkg::CFG_INHIBIT] || ignore_ff) begin
                        state_ff <= S_IDLE;
                    end else if (!hwAck) begin
                        state_ff <= S_SWACK;
                    end else if (addrMatch(shift_ff, own_ff, mask_ff)) begin
                        state_ff <= S_ACK;
                    end else begin
                        state_ff <= S_IDLE;
                        ignore_ff <= 1'b1;
                    end
                end
                S_SWACK: if (!ctrl_ff[sst_pkg::CTRL_SI]) begin
                    if (ctrl_ff[sst_pkg::CTRL_ACK]) begin
                        state_ff <= S_ACK;
                    end else begin
                        state_ff <= S_IDLE;
                        ignore_ff <= 1'b1;
                    end
                end
                S_ACK: if (sclFall) begin
                    state_ff <= shift_ff[0] ? S_TXWAIT : S_SKIP;
                end
                S_TXWAIT: if (!ctrl_ff[sst_pkg::CTRL_SI]) begin
                    state_ff <= dataWritten_ff ? S_TX : S_SKIP;
                end
                S_TX: if (byteEnd) begin
                    state_ff <= S_TXACK;
                    bitCnt_ff <= 4'h0;
                end
                S_TXACK: if (sclFall) begin
                    state_ff <= S_TXWAIT;
                end
                S_IDLE, S_SKIP: state_ff <= state_ff;
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // Event flag raised after the acknowledge cycle of a read address or a sent byte, or at the address for software ack.
    assign setSi = (state_ff == S_ADDR && byteEnd && !hwAck && !config_ff[sst_pkg::CFG_INHIBIT]
                    && !ignore_ff)
        || (state_ff == S_ACK && sclFall && shift_ff[0])
        || (state_ff == S_TXACK && sclFall)
        || (state_ff == S_TX && stopDet && bitCnt_ff != 4'h0)
        || (rateTick && mPhase_ff == 2'd1) || arbLoss;

    // ----------------------------------------
    // Shift register and data written marker.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_ff <= sst_pkg::RESET_BYTE;
            dataWritten_ff <= 1'b0;
        end else begin
            if (wrData) begin
                shift_ff <= sfrReq.data;
            end else if (sclRise && enabled && state_ff inside {S_ADDR, S_TX}) begin
                // Acknowledge clocks stay out, so the register keeps the whole bus byte.
                shift_ff <= {shift_ff[6:0], sda};
            end
            if (wrData) begin
                dataWritten_ff <= 1'b1;
            end else if (state_ff == S_TXACK || state_ff == S_IDLE) begin
                dataWritten_ff <= 1'b0;
            end
        end
    end

    // Outgoing bit moves only while the clock is low; a change under a high clock reads as START or STOP.
    always_ff @(posedge clk) begin
        if (reset) begin
            txBit_ff <= 1'b1;
        end else if (!scl) begin
            txBit_ff <= shift_ff[7];
        end
    end

    // ----------------------------------------
    // Bus bytes into the buffer.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset || !enabled) begin
            pendPush_ff <= 1'b0;
        end else if (byteEnd && state_ff inside {S_ADDR, S_TX}) begin
            pendPush_ff <= 1'b1;
        end else if (bufReady) begin
            pendPush_ff <= 1'b0;
        end
    end

    sst_byte_buf #(
        .WIDTH(8)
    ) u_buf (
        .clk(clk),
        .reset(reset),
        .inValid(pendPush_ff),
        .inReady(bufReady),
        .inData(shift_ff),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData)
    );

    // ----------------------------------------
    // Control register: status vector and flags.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_ff <= sst_pkg::RESET_BYTE;
        end else begin
            if (wrCtrl) begin
                ctrl_ff[sst_pkg::CTRL_STA] <= sfrReq.data[sst_pkg::CTRL_STA];
                ctrl_ff[sst_pkg::CTRL_STO] <= sfrReq.data[sst_pkg::CTRL_STO];
                ctrl_ff[sst_pkg::CTRL_ACK] <= sfrReq.data[sst_pkg::CTRL_ACK];
                ctrl_ff[sst_pkg::CTRL_ARBITRATION_LOST_FLAG] <= ctrl_ff[sst_pkg::CTRL_ARBITRATION_LOST_FLAG]
                    & sfrReq.data[sst_pkg::CTRL_ARBITRATION_LOST_FLAG];
            end
            // Set beats the software clear so no event is lost.
            ctrl_ff[sst_pkg::CTRL_SI] <= setSi || (ctrl_ff[sst_pkg::CTRL_SI]
                && !(wrCtrl && !sfrReq.data[sst_pkg::CTRL_SI]));
            if (setSi) begin
                ctrl_ff[sst_pkg::CTRL_ACK_REQUEST_FLAG] <= state_ff == S_ADDR;
            end else if (wrCtrl && !sfrReq.data[sst_pkg::CTRL_SI]) begin
                ctrl_ff[sst_pkg::CTRL_ACK_REQUEST_FLAG] <= 1'b0;
            end
            // An acknowledged address counts as ACK, so the first data load is no error.
            if (state_ff == S_ACK && sclFall) begin
                ctrl_ff[sst_pkg::CTRL_ACK] <= 1'b1;
            end
            if (state_ff == S_TXACK && sclRise) begin
                ctrl_ff[sst_pkg::CTRL_ACK] <= !sda;
            end
            // Writing data after a NACK, before the flag is cleared, is an error.
            if (wrData && state_ff == S_TXWAIT && !ctrl_ff[sst_pkg::CTRL_ACK]) begin
                ctrl_ff[sst_pkg::CTRL_ARBITRATION_LOST_FLAG] <= 1'b1;
            end
            if (arbLoss) begin
                ctrl_ff[sst_pkg::CTRL_ARBITRATION_LOST_FLAG] <= 1'b1;
            end
            if (state_ff == S_TX && stopDet && bitCnt_ff != 4'h0) begin
                ctrl_ff[sst_pkg::CTRL_STO] <= 1'b1;
            end
            if (mPhase_ff == 2'd3 && rateTick) begin
                ctrl_ff[sst_pkg::CTRL_STO] <= 1'b0;
            end
            ctrl_ff[sst_pkg::CTRL_MASTER] <= mPhase_ff == 2'd2 || mPhase_ff == 2'd3;
            ctrl_ff[sst_pkg::CTRL_TRANSMIT_DIRECTION_FLAG] <= state_ff inside {S_TX, S_TXACK, S_TXWAIT};
        end
    end

    // ----------------------------------------
    // Configuration, address, mask and timing.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            config_ff <= sst_pkg::RESET_BYTE;
            timing_ff <= sst_pkg::RESET_BYTE;
            own_ff <= sst_pkg::RESET_BYTE;
            mask_ff <= sst_pkg::RESET_BYTE;
        end else if (sfrReq.wr) begin
            case (sfrReq.addr)
                sst_pkg::ADDR_CONFIG: config_ff <= sfrReq.data & 8'hc3;
                // Reserved timing bits keep their reset value whatever is written.
                sst_pkg::ADDR_TIMING: timing_ff <= sfrReq.data & 8'h83;
                sst_pkg::ADDR_OWN: own_ff <= sfrReq.data;
                sst_pkg::ADDR_MASK: mask_ff <= sfrReq.data;
                default: config_ff <= config_ff;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads, one cycle after the strobe.
    // ----------------------------------------
    always_comb begin
        case (sfrReq.addr)
            sst_pkg::ADDR_CTRL: nxt_rdData = ctrl_ff;
            sst_pkg::ADDR_CONFIG: nxt_rdData = config_ff | {2'b00, state_ff != S_IDLE, 5'h00};
            sst_pkg::ADDR_DATA: nxt_rdData = shift_ff;
            sst_pkg::ADDR_TIMING: nxt_rdData = timing_ff;
            sst_pkg::ADDR_OWN: nxt_rdData = own_ff;
            sst_pkg::ADDR_MASK: nxt_rdData = mask_ff;
            default: nxt_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_ff <= sst_pkg::RESET_BYTE;
        end else if (sfrReq.rd) begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign sfrRdData = rdData_ff;
    assign eventFlag = ctrl_ff[sst_pkg::CTRL_SI];

endmodule : sst_slave_tx

// file: design/sst_pkg.sv
package sst_pkg;

    // ----------------------------------------
    // Register addresses on the register port.
    // ----------------------------------------
    localparam logic [7:0] ADDR_TIMING = 8'hac;
    localparam logic [7:0] ADDR_CTRL = 8'hc0;
    localparam logic [7:0] ADDR_CONFIG = 8'hc1;
    localparam logic [7:0] ADDR_DATA = 8'hc2;
    localparam logic [7:0] ADDR_MASK = 8'hd6;
    localparam logic [7:0] ADDR_OWN = 8'hd7;

    // ----------------------------------------
    // Field positions and reset values.
    // ----------------------------------------
    localparam int CTRL_MASTER = 7;
    localparam int CTRL_TRANSMIT_DIRECTION_FLAG = 6;
    localparam int CTRL_STA = 5;
    localparam int CTRL_STO = 4;
    localparam int CTRL_ACK_REQUEST_FLAG = 3;
    localparam int CTRL_ARBITRATION_LOST_FLAG = 2;
    localparam int CTRL_ACK = 1;
    localparam int CTRL_SI = 0;
    localparam int CFG_ENABLE = 7;
    localparam int CFG_INHIBIT = 6;
    localparam int CFG_BUSY = 5;
    localparam int TC_SWAP = 7;
    localparam int OWN_GC = 0;
    localparam int MASK_HWACK = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] GENERAL_CALL = 8'h00;

    // ----------------------------------------
    // Start detection hold windows in system clocks.
    // ----------------------------------------
    localparam logic [3:0] SDD_WIN0 = 4'h0;
    localparam logic [3:0] SDD_WIN1 = 4'h2;
    localparam logic [3:0] SDD_WIN2 = 4'h4;
    localparam logic [3:0] SDD_WIN3 = 4'h8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ----------------------------------------
    // Types.
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } sst_sfr_req_t;

    typedef struct packed {
        logic lowIn;
        logic highIn;
    } sst_pin_in_t;

    typedef enum logic [1:0] {
        SRC_T0,
        SRC_T1,
        SRC_T2H,
        SRC_T2L
    } sst_rate_src_t;

endpackage : sst_pkg

// file: design/sst_byte_buf.sv
`timescale 1ns/1ps

// Two-entry buffer; a full buffer drops inReady so the source stalls.
module sst_byte_buf #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    initial begin
        if (WIDTH < 1) begin
            $error("sst_byte_buf needs WIDTH of at least one");
        end
    end

    logic [WIDTH-1:0] slot_ff [2];
    logic [1:0] count_ff;
    logic rdPtr_ff;
    logic wrPtr_ff;
    logic push;
    logic pop;

    // Handshakes are combinational, the data word comes from the slots.
    assign inReady = (count_ff != 2'd2);
    assign outValid = (count_ff != 2'd0);
    assign outData = slot_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointers and fill count.
    always_ff @(posedge clk) begin
        if (reset) begin
            count_ff <= 2'd0;
            rdPtr_ff <= 1'b0;
            wrPtr_ff <= 1'b0;
        end else begin
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (pop) begin
                rdPtr_ff <= ~rdPtr_ff;
            end
        end
    end

    // Storage; no reset needed since outValid guards it.
    always_ff @(posedge clk) begin
        if (push) begin
            slot_ff[wrPtr_ff] <= inData;
        end
    end

endmodule : sst_byte_buf

// file: verif/sst_slave_tx_assertions.sv
`timescale 1ns/1ps
module sst_slave_tx_assertions (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port and ticks.
    input wire sst_pkg::sst_sfr_req_t sfrReq,
    input wire logic [7:0] sfrRdData,
    input wire logic [3:0] timerOvf,
    // Pins.
    input wire sst_pkg::sst_pin_in_t pinIn,
    input wire logic pinLowOut,
    input wire logic pinLowOeN,
    input wire logic pinHighOut,
    input wire logic pinHighOeN,
    // Stream and flag.
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] rxData,
    input wire logic eventFlag
);
    logic [7:0] tc_ff;
    logic [1:0] rate_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow of the timing register; reserved bits never hold a one.
    always_ff @(posedge clk) begin
        if (reset) tc_ff <= 8'h00;
        else if (sfrReq.wr && sfrReq.addr == sst_pkg::ADDR_TIMING) tc_ff <= sfrReq.data & 8'h83;
    end
    // Shadow of the rate select.
    always_ff @(posedge clk) begin
        if (reset) rate_ff <= 2'h0;
        else if (sfrReq.wr && sfrReq.addr == sst_pkg::ADDR_CONFIG) rate_ff <= sfrReq.data[1:0];
    end
    a_reset_idle: assert property ($past(reset) |-> pinLowOeN && pinHighOeN && !rxValid && !eventFlag)
        else $error("outputs not idle after reset");
    a_open_drain: assert property (!pinLowOut && !pinHighOut)
        else $error("pin driven high");
    a_stall_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
        else $error("stalled byte lost");
    a_flag_sticky: assert property (eventFlag && !(sfrReq.wr && sfrReq.addr == sst_pkg::ADDR_CTRL
        && !sfrReq.data[0]) |=> eventFlag)
        else $error("event flag dropped alone");
    a_flag_status: assert property (sfrReq.rd && sfrReq.addr == sst_pkg::ADDR_CTRL |=> sfrRdData[0] == $past(eventFlag))
        else $error("control read disagrees with flag");
    a_timing_read: assert property (sfrReq.rd && sfrReq.addr == sst_pkg::ADDR_TIMING |=> sfrRdData == $past(tc_ff))
        else $error("timing read back wrong");
    a_rate_read: assert property (sfrReq.rd && sfrReq.addr == sst_pkg::ADDR_CONFIG |=> sfrRdData[1:0] == $past(rate_ff))
        else $error("rate select read back wrong");
    a_rd_stands: assert property (!$past(sfrReq.rd) |-> $stable(sfrRdData))
        else $error("read data moved without read");
    c_taken: cover property (rxValid && rxReady);
    c_event: cover property ($rose(eventFlag));
    c_pull: cover property (!pinLowOeN);
endmodule : sst_slave_tx_assertions

bind sst_slave_tx sst_slave_tx_assertions chk_u (.clk, .reset, .sfrReq, .sfrRdData, .timerOvf, .pinIn, .pinLowOut,
    .pinLowOeN, .pinHighOut, .pinHighOeN, .rxValid, .rxReady, .rxData, .eventFlag);

// file: verif/sst_bus_master_model.sv
`timescale 1ns/1ps
module sst_bus_master_model (
    // Device pull-downs and pin order.
    input wire logic swap,
    input wire logic lowOeN,
    input wire logic highOeN,
    // Levels seen by the device.
    output logic lowIn,
    output logic highIn
);
    logic sda = 1'b1;
    logic scl = 1'b1;
    logic sdaW, sclW;
    int stalls = 0;
    // Open-drain wires with pull-ups; the clock stands high between frames.
    assign sdaW = sda & (swap ? highOeN : lowOeN);
    assign sclW = scl & (swap ? lowOeN : highOeN);
    assign lowIn = swap ? sclW : sdaW;
    assign highIn = swap ? sdaW : sclW;
    // One bit; a held clock is waited out, with a bound so a stuck bus is seen.
    task automatic bit_io(input logic b, output logic s);
        sda = b;
        #16 scl = 1'b1;
        for (int i = 0; i < 300 && !sclW; i++) #5;
        if (!sclW) stalls++;
        #16 s = sdaW;
        #16 scl = 1'b0;
        #16;
    endtask : bit_io
    // A byte and its acknowledge; a released line reads as the pull-up.
    task automatic xfer(input logic [7:0] o, output logic [7:0] i, input logic ackOut, output logic ackIn);
        for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
        bit_io(ackOut, ackIn);
    endtask : xfer
    // Data falls well ahead of clock, longer than the widest window.
    task automatic start();
        sda = 1'b1;
        scl = 1'b1;
        #32 sda = 1'b0;
        #48 scl = 1'b0;
        #16;
    endtask : start
    task automatic stop();
        sda = 1'b0;
        #16 scl = 1'b1;
        #32 sda = 1'b1;
        #32;
    endtask : stop
endmodule : sst_bus_master_model

// file: verif/sst_slave_tx_tb_top.sv
`timescale 1ns/1ps
module sst_slave_tx_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    sst_pkg::sst_sfr_req_t sfrReq = '0;
    logic [3:0] timerOvf = 4'h0;
    logic rxReady = 1'b0;
    logic swap = 1'b0;
    wire sst_pkg::sst_pin_in_t pinIn;
    wire logic pinLowIn;
    wire logic pinHighIn;
    assign pinIn = {pinLowIn, pinHighIn};
    logic [7:0] sfrRdData, rxData, rd, got;
    logic pinLowOut, pinLowOeN, pinHighOut, pinHighOeN, rxValid, eventFlag, ak, rdy;
    logic [7:0] regs[4] = '{sst_pkg::ADDR_TIMING, sst_pkg::ADDR_CTRL, sst_pkg::ADDR_CONFIG, 8'h00};
    logic [7:0] expQ[$];
    int n_fail = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    sst_slave_tx dut_u (.clk(clk), .reset(reset), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .timerOvf(timerOvf),
        .pinIn(pinIn), .pinLowOut(pinLowOut), .pinLowOeN(pinLowOeN), .pinHighOut(pinHighOut),
        .pinHighOeN(pinHighOeN), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .eventFlag(eventFlag));
    sst_bus_master_model bm_u (.swap(swap), .lowOeN(pinLowOeN), .highOeN(pinHighOeN), .lowIn(pinLowIn),
        .highIn(pinHighIn));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // One-cycle register access; read data is taken the cycle after.
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrReq = '{wr: w, rd: !w, addr: a, data: d};
        @(negedge clk);
        sfrReq = '0;
        rd = sfrRdData;
    endtask : sfr
    task automatic wait_flag();
        for (int i = 0; i < 400 && eventFlag !== 1'b1; i++) @(negedge clk);
        check(8'(eventFlag), 8'h01);
    endtask : wait_flag
    // A read from the slave: n data bytes follow a matched address, the last one refused.
    task automatic slave_read(input logic [7:0] adr, input logic expAck, input int n);
        logic [7:0] tx;
        bm_u.start();
        expQ.push_back(adr);
        bm_u.xfer(adr, got, 1'b1, ak);
        check(8'(ak), 8'(!expAck));
        for (int k = 0; k < n && expAck; k++) begin
            wait_flag();
            tx = 8'($urandom());
            sfr(1'b1, sst_pkg::ADDR_DATA, tx);
            sfr(1'b1, sst_pkg::ADDR_CTRL, 8'h00);
            expQ.push_back(tx);
            bm_u.xfer(8'hff, got, k == n - 1, ak);
            check(got, tx);
            wait_flag();
            sfr(1'b0, sst_pkg::ADDR_CTRL, 8'h00);
            check(rd, {6'b010000, k != n - 1, 1'b1});
        end
        sfr(1'b1, sst_pkg::ADDR_CTRL, 8'h00);
        repeat (10) @(negedge clk);
        check(8'(eventFlag), 8'h00);
        bm_u.stop();
    endtask : slave_read
    // Every bus byte must come out of the stream in order.
    // Random stalls and rate ticks; a waiting byte is compared while it stands, before the edge that takes it.
    always @(negedge clk) begin
        rdy = $urandom_range(0, 2) == 0;
        if (rxValid === 1'b1 && rdy) check(rxData, expQ.pop_front());
        rxReady <= rdy;
        timerOvf <= 4'($urandom());
    end
    initial begin
        void'($urandom(32'hbc18));
        repeat (6) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        foreach (regs[k]) begin
            sfr(1'b0, regs[k], 8'h00);
            check(rd, 8'h00);
        end
        for (int k = 0; k < 4; k++) begin
            got = 8'($urandom()) & 8'h83;
            sfr(1'b1, sst_pkg::ADDR_TIMING, got);
            sfr(1'b0, sst_pkg::ADDR_TIMING, 8'h00);
            check(rd, got & 8'h83);
            sfr(1'b1, sst_pkg::ADDR_CONFIG, 8'h80 | 8'(k));
            sfr(1'b0, sst_pkg::ADDR_CONFIG, 8'h00);
            check(rd, 8'h80 | 8'(k));
        end
        sfr(1'b1, sst_pkg::ADDR_OWN, 8'h68);
        sfr(1'b1, sst_pkg::ADDR_MASK, 8'hf9);
        for (int s = 0; s < 2; s++) begin
            swap = s[0];
            sfr(1'b1, sst_pkg::ADDR_TIMING, {swap, 5'h00, 2'(s * 3)});
            sfr(1'b1, sst_pkg::ADDR_CONFIG, 8'h80);
            slave_read({5'h0d, 2'($urandom()), 1'b1}, 1'b1, 3);
            slave_read(8'h99, 1'b0, 0);
            sfr(1'b1, sst_pkg::ADDR_CONFIG, 8'hc0);
            slave_read(8'h69, 1'b0, 0);
        end
        for (int i = 0; i < 400 && expQ.size() > 0; i++) @(negedge clk);
        check(8'(expQ.size()), 8'h00);
        check(8'(bm_u.stalls), 8'h00);
        complete_run();
    end
endmodule : sst_slave_tx_tb_top
